//--- rtl/lvrst_delay.sv
`timescale 1ns/100ps
`default_nettype none
module lvrst_delay
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Condition that must persist
   input wire logic bad_level,
   // Result
   output logic fire
);
   typedef struct packed
   {
      logic [7:0] cnt;
      logic fire;
   } lvrst_delay_state_t;

   lvrst_delay_state_t s_reg;
   lvrst_delay_state_t s_next;

   // Delay aborts if software repairs the code before it expires
   always_comb
   begin
      s_next = s_reg;
      s_next.fire = 1'b0;
      if (!bad_level || s_reg.fire)
      begin
         s_next.cnt = 8'h00;
      end
      else if (s_reg.cnt == 8'(lvrst_pkg::SRESET_CYC - 8'h01))
      begin
         s_next.fire = 1'b1;
         s_next.cnt = 8'h00;
      end
      else
      begin
         s_next.cnt = 8'(s_reg.cnt + 8'h01);
      end
   end

   // State register
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign fire = s_reg.fire;

   delay_len_a: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(fire) |-> $past(bad_level, 2) && $past(bad_level, 1))
      else $error("bad-code reset without persistent bad code");
endmodule
`default_nettype wire

//--- rtl/lvrst_pkg.sv
// How it works
// - Monitoring off in sleep or idle, otherwise on
// - Supply low only between 0.9V and trip
// - Short low pulses ignored, persistent ones reset chip
// - Width code gives 8, 32, 64, 128 periods
// - Four trip codes select four trip voltages
// - Undefined trip code resets after fixed delay
// - Undervoltage reset keeps trip register contents
// - Bad-code reset restores trip register power-on value
// - Qualified undervoltage reset sets flag bit 2
// - Undefined trip code sets flag bit 1
// - Hardware sets flags, only software clears them
// - Unimplemented flag and width bits read zero
// - Writing 55H to programming control resets device
// - Running watchdog timeout resets and sets timeout
// - Sleeping watchdog timeout clears PC, SP only
// - Timeout and powerdown flags follow reset kind
// - Power-on puts whole core into reset state
// - Reset-control fault sets flag bit 3
package lvrst_pkg;
   // Register byte offsets on the APB
   localparam logic [7:0] OFS_TRIP = 8'h00;
   localparam logic [7:0] OFS_WIDTH = 8'h04;
   localparam logic [7:0] OFS_FLAGS = 8'h08;
   localparam logic [7:0] OFS_PROG = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   // Values after power-on
   localparam logic [7:0] TRIP_POR = 8'h55;
   localparam logic [1:0] WIDTH_POR = 2'h1;
   localparam logic [3:0] FLAGS_POR = 4'h0;
   // Defined trip codes and the programming reset code
   localparam logic [7:0] CODE_2V10 = 8'h5a;
   localparam logic [7:0] CODE_2V55 = 8'h33;
   localparam logic [7:0] CODE_3V15 = 8'h99;
   localparam logic [7:0] CODE_3V80 = 8'haa;
   localparam logic [7:0] PROG_RESET_CODE = 8'h55;
   // Flag bit positions
   localparam int FLAG_WDT = 0;
   localparam int FLAG_BAD = 1;
   localparam int FLAG_LV = 2;
   localparam int FLAG_RST = 3;
   // Qualification limits in slow oscillator ticks
   localparam logic [7:0] LIM_W0 = 8'h08;
   localparam logic [7:0] LIM_W1 = 8'h20;
   localparam logic [7:0] LIM_W2 = 8'h40;
   localparam logic [7:0] LIM_W3 = 8'h80;
   // Software reset delay
   localparam int CLK_PERIOD_NS = 10;
   localparam int SRESET_NS = 160;
   localparam int SRESET_CYC_I =
      (SRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] SRESET_CYC = 8'(SRESET_CYC_I);
endpackage

//--- rtl/lvrst_qual.sv
`timescale 1ns/100ps
`default_nettype none
module lvrst_qual
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Qualification inputs
   input wire logic slow_tick,
   input wire logic low_ind,
   input wire logic clear,
   input wire logic [1:0] low_width_code,
   // Result
   output logic fire
);
   typedef struct packed
   {
      logic [7:0] cnt;
      logic fire;
   } lvrst_qual_state_t;

   lvrst_qual_state_t s_reg;
   lvrst_qual_state_t s_next;
   logic [7:0] limit;
   logic [7:0] cnt_inc;

   // Width code to tick count; phase of first tick gives the N-1..N spread
   always_comb
   begin
      case (low_width_code)
         2'h0: limit = lvrst_pkg::LIM_W0;
         2'h1: limit = lvrst_pkg::LIM_W1;
         2'h2: limit = lvrst_pkg::LIM_W2;
         default: limit = lvrst_pkg::LIM_W3;
      endcase
   end

   // Counter restarts as soon as the low indication drops
   always_comb
   begin
      s_next = s_reg;
      s_next.fire = 1'b0;
      cnt_inc = 8'(s_reg.cnt + 8'h01);
      if (clear || !low_ind)
      begin
         s_next.cnt = 8'h00;
      end
      else if (slow_tick)
      begin
         if (cnt_inc == limit)
         begin
            s_next.fire = 1'b1;
            s_next.cnt = 8'h00;
         end
         else
         begin
            s_next.cnt = cnt_inc;
         end
      end
   end

   // State register
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign fire = s_reg.fire;

   short_low_a: assert property (@(posedge ref_clk) disable iff (reset)
      fire |-> $past(low_ind) && $past(slow_tick))
      else $error("qualified without low indication");
   restart_a: assert property (@(posedge ref_clk) disable iff (reset)
      !low_ind |=> s_reg.cnt == 8'h00)
      else $error("counter did not restart");
endmodule
`default_nettype wire

//--- rtl/lvrst_top.sv
`timescale 1ns/100ps
`default_nettype none
module lvrst_top
(
   // Clock and power-on reset
   input wire logic ref_clk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Supply comparator and slow oscillator
   input wire logic slow_internal_osc,
   input wire logic supply_above_0v9,
   input wire logic supply_below_trip,
   // Power mode and other reset sources
   input wire logic sleep_idle,
   input wire logic wdt_timeout,
   input wire logic reset_pin_ctrl_fault,
   input wire logic watchdog_ctrl_fault,
   // Reset outputs to the core
   output logic chip_reset,
   output logic pc_sp_clear,
   output logic monitor_active,
   output logic [1:0] trip_voltage,
   output logic timeout_status_flag,
   output logic powerdown_status_flag
);
   typedef struct packed
   {
      logic [7:0] trip_level_code;
      logic [1:0] low_width_code;
      logic [3:0] flags;
      logic tmo;
      logic pwd;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic chip_reset;
      logic pcsp_clear;
      logic mon_en;
      logic [1:0] level;
   } lvrst_top_state_t;

   lvrst_top_state_t s_reg;
   lvrst_top_state_t s_next;
   logic low_ind;
   logic lv_fire;
   logic bad_fire;
   logic code_bad;
   logic setup;
   logic access;
   logic wr;
   logic prog_hit;
   logic wdt_run;
   logic wdt_sleep;
   logic any_reset;
   logic restore_trip;
   logic [2:0] code_dec;

   // Map a trip code to a level index, bit 2 high when undefined
   function automatic logic [2:0] lvrst_decode(input logic [7:0] code);
      case (code)
         lvrst_pkg::CODE_2V10: lvrst_decode = 3'h0;
         lvrst_pkg::CODE_2V55: lvrst_decode = 3'h1;
         lvrst_pkg::CODE_3V15: lvrst_decode = 3'h2;
         lvrst_pkg::CODE_3V80: lvrst_decode = 3'h3;
         default: lvrst_decode = 3'h4;
      endcase
   endfunction

   // Address check used only for the error answer; the read mux compares paddr itself
   function automatic logic lvrst_mapped(input logic [7:0] a);
      lvrst_mapped = (a == lvrst_pkg::OFS_TRIP) ||
         (a == lvrst_pkg::OFS_WIDTH) || (a == lvrst_pkg::OFS_FLAGS) ||
         (a == lvrst_pkg::OFS_PROG) || (a == lvrst_pkg::OFS_STATUS);
   endfunction

   // Low only while above 0.9V and under the trip level, and monitoring on
   assign low_ind = supply_above_0v9 && supply_below_trip &&
      s_reg.mon_en;

   // Code checked every cycle, even with monitoring off
   assign code_dec = lvrst_decode(s_reg.trip_level_code);
   assign code_bad = code_dec[2];

   // Width qualification on slow oscillator ticks
   lvrst_qual u_qual
   (
      .ref_clk(ref_clk),
      .reset(reset),
      .slow_tick(slow_internal_osc),
      .low_ind(low_ind),
      .clear(s_reg.chip_reset),
      .low_width_code(s_reg.low_width_code),
      .fire(lv_fire)
   );

   // Fixed delay before the bad-code reset
   lvrst_delay u_delay
   (
      .ref_clk(ref_clk),
      .reset(reset),
      .bad_level(code_bad),
      .fire(bad_fire)
   );

   // Bus phases; pready answers in the cycle after setup
   assign setup = psel && !penable;
   assign access = psel && penable && s_reg.pready;
   assign wr = access && pwrite && !s_reg.pslverr;
   assign prog_hit = wr && (paddr == lvrst_pkg::OFS_PROG) &&
      (pwdata[7:0] == lvrst_pkg::PROG_RESET_CODE);
   assign wdt_run = wdt_timeout && !sleep_idle;
   assign wdt_sleep = wdt_timeout && sleep_idle;
   assign any_reset = lv_fire || bad_fire || prog_hit || wdt_run ||
      reset_pin_ctrl_fault || watchdog_ctrl_fault;
   // Only the undervoltage reset keeps the trip code
   assign restore_trip = bad_fire || prog_hit || wdt_run ||
      reset_pin_ctrl_fault || watchdog_ctrl_fault;

   // Next state: bus, flags and reset sequencing
   always_comb
   begin
      s_next = s_reg;
      s_next.pready = 1'b0;
      s_next.pslverr = 1'b0;
      s_next.chip_reset = 1'b0;
      s_next.pcsp_clear = 1'b0;
      s_next.mon_en = !sleep_idle;
      s_next.level = code_dec[1:0];
      // Read data captured at setup, held through the access cycle
      if (setup)
      begin
         s_next.pready = 1'b1;
         s_next.pslverr = !lvrst_mapped(paddr);
         if (paddr == lvrst_pkg::OFS_TRIP)
         begin
            s_next.prdata = {24'h00_0000, s_reg.trip_level_code};
         end
         else if (paddr == lvrst_pkg::OFS_WIDTH)
         begin
            s_next.prdata = {30'h0, s_reg.low_width_code};
         end
         else if (paddr == lvrst_pkg::OFS_FLAGS)
         begin
            s_next.prdata = {28'h000_0000, s_reg.flags};
         end
         else if (paddr == lvrst_pkg::OFS_STATUS)
         begin
            s_next.prdata = {30'h0, s_reg.pwd, s_reg.tmo};
         end
         else
         begin
            s_next.prdata = 32'h0000_0000;
         end
      end
      // Register writes take effect at the access edge
      if (wr && paddr == lvrst_pkg::OFS_TRIP)
      begin
         s_next.trip_level_code = pwdata[7:0];
      end
      if (wr && paddr == lvrst_pkg::OFS_WIDTH)
      begin
         s_next.low_width_code = pwdata[1:0];
      end
      // Software may only clear flags: a written 0 clears, a 1 is ignored
      if (wr && paddr == lvrst_pkg::OFS_FLAGS)
      begin
         s_next.flags = s_reg.flags & pwdata[3:0];
      end
      // Hardware sets come after the clear so a coincident set wins
      if (lv_fire)
      begin
         s_next.flags[lvrst_pkg::FLAG_LV] = 1'b1;
      end
      if (bad_fire || code_bad)
      begin
         s_next.flags[lvrst_pkg::FLAG_BAD] = 1'b1;
      end
      if (reset_pin_ctrl_fault)
      begin
         s_next.flags[lvrst_pkg::FLAG_RST] = 1'b1;
      end
      if (watchdog_ctrl_fault)
      begin
         s_next.flags[lvrst_pkg::FLAG_WDT] = 1'b1;
      end
      // Watchdog in sleep: only PC and SP are cleared
      if (wdt_sleep)
      begin
         s_next.pcsp_clear = 1'b1;
         s_next.tmo = 1'b1;
         s_next.pwd = 1'b1;
      end
      // Chip resets keep both status flags; a running watchdog sets timeout
      if (any_reset)
      begin
         s_next.chip_reset = 1'b1;
         s_next.low_width_code = lvrst_pkg::WIDTH_POR;
         if (wdt_run)
         begin
            s_next.tmo = 1'b1;
         end
         if (restore_trip)
         begin
            s_next.trip_level_code = lvrst_pkg::TRIP_POR;
         end
         else
         begin
            s_next.trip_level_code = s_reg.trip_level_code;
         end
      end
   end

   // Power-on holds the core in reset and clears status and flags
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         s_reg <= '0;
         s_reg.trip_level_code <= lvrst_pkg::TRIP_POR;
         s_reg.low_width_code <= lvrst_pkg::WIDTH_POR;
         s_reg.flags <= lvrst_pkg::FLAGS_POR;
         s_reg.chip_reset <= 1'b1;
         s_reg.mon_en <= 1'b1;
         s_reg.level <= 2'h0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register
   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign chip_reset = s_reg.chip_reset;
   assign pc_sp_clear = s_reg.pcsp_clear;
   assign monitor_active = s_reg.mon_en;
   assign trip_voltage = s_reg.level;
   assign timeout_status_flag = s_reg.tmo;
   assign powerdown_status_flag = s_reg.pwd;

   mon_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
      sleep_idle |=> !monitor_active && !low_ind)
      else $error("monitoring active in sleep");
   lv_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
      lv_fire |=> s_reg.flags[lvrst_pkg::FLAG_LV] && chip_reset)
      else $error("undervoltage reset without flag");
   bad_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
      bad_fire |=> s_reg.flags[lvrst_pkg::FLAG_BAD] &&
         s_reg.trip_level_code == lvrst_pkg::TRIP_POR && chip_reset)
      else $error("bad-code reset handled wrongly");
   lv_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
      lv_fire && !restore_trip |=>
         s_reg.trip_level_code == $past(s_reg.trip_level_code))
      else $error("trip code changed by undervoltage reset");
   prog_rst_a: assert property (@(posedge ref_clk) disable iff (reset)
      prog_hit |=> chip_reset ##1 !chip_reset || $past(any_reset))
      else $error("programming reset missing");
   wdt_run_a: assert property (@(posedge ref_clk) disable iff (reset)
      wdt_run |=> chip_reset && timeout_status_flag)
      else $error("running watchdog reset wrong");
   wdt_sleep_a: assert property (@(posedge ref_clk) disable iff (reset)
      wdt_sleep && !any_reset |=> pc_sp_clear && !chip_reset &&
         timeout_status_flag && powerdown_status_flag)
      else $error("sleeping watchdog reset wrong");
   flag_clr_a: assert property (@(posedge ref_clk) disable iff (reset)
      $fell(s_reg.flags[lvrst_pkg::FLAG_LV]) |->
         $past(wr) && $past(paddr) == lvrst_pkg::OFS_FLAGS)
      else $error("flag cleared without software write");
   ctrl_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
      reset_pin_ctrl_fault |=> s_reg.flags[lvrst_pkg::FLAG_RST])
      else $error("reset-control flag not set");
   ro_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
      pready && $past(paddr) == lvrst_pkg::OFS_FLAGS |-> prdata[31:4] == 0)
      else $error("unimplemented bits read nonzero");
   por_clear_a: assert property (@(posedge ref_clk)
      $fell(reset) |-> chip_reset && !timeout_status_flag &&
         !powerdown_status_flag && s_reg.flags == 4'h0)
      else $error("power-on state wrong");

   // Level index follows each defined code one cycle later
   lvl_2v10_a: assert property (@(posedge ref_clk) disable iff (reset)
      s_reg.trip_level_code == lvrst_pkg::CODE_2V10 |=> trip_voltage == 2'h0)
      else $error("level index wrong for lowest code");
   lvl_2v55_a: assert property (@(posedge ref_clk) disable iff (reset)
      s_reg.trip_level_code == lvrst_pkg::CODE_2V55 |=> trip_voltage == 2'h1)
      else $error("level index wrong for second code");
   lvl_3v15_a: assert property (@(posedge ref_clk) disable iff (reset)
      s_reg.trip_level_code == lvrst_pkg::CODE_3V15 |=> trip_voltage == 2'h2)
      else $error("level index wrong for third code");
   lvl_3v80_a: assert property (@(posedge ref_clk) disable iff (reset)
      s_reg.trip_level_code == lvrst_pkg::CODE_3V80 |=> trip_voltage == 2'h3)
      else $error("level index wrong for highest code");
   wid_ro_a: assert property (@(posedge ref_clk) disable iff (reset)
      pready && $past(paddr) == lvrst_pkg::OFS_WIDTH |-> prdata[31:2] == 0)
      else $error("unimplemented width bits read nonzero");
   // Status flags: only the watchdog may touch them after power-on
   pin_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
      reset_pin_ctrl_fault && !wdt_timeout |=>
         timeout_status_flag == $past(timeout_status_flag) &&
         powerdown_status_flag == $past(powerdown_status_flag))
      else $error("reset-control reset changed status flags");
   lv_stat_a: assert property (@(posedge ref_clk) disable iff (reset)
      lv_fire && !wdt_timeout |=>
         timeout_status_flag == $past(timeout_status_flag) &&
         powerdown_status_flag == $past(powerdown_status_flag))
      else $error("undervoltage reset changed status flags");
   wdt_pdf_a: assert property (@(posedge ref_clk) disable iff (reset)
      wdt_run |=> powerdown_status_flag == $past(powerdown_status_flag))
      else $error("running watchdog changed powerdown flag");
   bad_set_a: assert property (@(posedge ref_clk) disable iff (reset)
      code_bad |=> s_reg.flags[lvrst_pkg::FLAG_BAD])
      else $error("undefined code did not set its flag");
   prog_cmd_a: assert property (@(posedge ref_clk) disable iff (reset)
      psel && penable && pready && pwrite && paddr == lvrst_pkg::OFS_PROG &&
         pwdata[7:0] == lvrst_pkg::PROG_RESET_CODE |=> chip_reset)
      else $error("programming command gave no reset");
   flag_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
      !(wr && paddr == lvrst_pkg::OFS_FLAGS) |=>
         (s_reg.flags & $past(s_reg.flags)) == $past(s_reg.flags))
      else $error("flag lost without software write");
   mon_on_a: assert property (@(posedge ref_clk) disable iff (reset)
      !sleep_idle |=> monitor_active)
      else $error("monitoring off while running");
   pcsp_src_a: assert property (@(posedge ref_clk) disable iff (reset)
      pc_sp_clear |-> $past(wdt_timeout) && $past(sleep_idle))
      else $error("PC and SP cleared without sleeping timeout");
   wid_por_a: assert property (@(posedge ref_clk) disable iff (reset)
      any_reset |=> s_reg.low_width_code == lvrst_pkg::WIDTH_POR)
      else $error("width code not restored by chip reset");
   rst_src_a: assert property (@(posedge ref_clk) disable iff (reset)
      chip_reset && !$past(reset) |-> $past(any_reset))
      else $error("chip reset without a source");
   dead_sup_a: assert property (@(posedge ref_clk) disable iff (reset)
      !supply_above_0v9 |-> !low_ind)
      else $error("supply under 0.9V treated as low");
endmodule
`default_nettype wire

//--- test/low_voltage_reset_and_flags_tb.sv
`timescale 1ns/100ps
`default_nettype none
module low_voltage_reset_and_flags_tb;
   localparam logic [7:0] A_TRIP = lvrst_pkg::OFS_TRIP;
   localparam logic [7:0] A_WID = lvrst_pkg::OFS_WIDTH;
   localparam logic [7:0] A_FLG = lvrst_pkg::OFS_FLAGS;
   localparam logic [31:0] GOOD = 32'h0000_005a;
   logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, bad;
   logic [31:0] pwdata, prdata, rd;
   logic osc, above, below, sag, dead, sleep_idle, wdt_timeout;
   logic pin_flt, wd_flt, chip_reset, pc_sp_clear, mon, tmo_f, pwd_f;
   logic [1:0] trip_voltage;
   logic [7:0] codes [4];
   int failures = 0;
   int tests_run = 0;
   int rst_seen = 0;
   int psc_seen = 0;
   int seed_v, s;
   // Device and the supply side
   lvrst_top dut
   (
      .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .slow_internal_osc(osc),
      .supply_above_0v9(above), .supply_below_trip(below),
      .sleep_idle(sleep_idle), .wdt_timeout(wdt_timeout),
      .reset_pin_ctrl_fault(pin_flt), .watchdog_ctrl_fault(wd_flt),
      .chip_reset(chip_reset), .pc_sp_clear(pc_sp_clear),
      .monitor_active(mon), .trip_voltage(trip_voltage),
      .timeout_status_flag(tmo_f), .powerdown_status_flag(pwd_f)
   );
   lvrst_supply_model #(.TICK_DIV(4)) supply
   (
      .ref_clk(ref_clk), .reset(reset), .sag(sag), .dead(dead),
      .slow_internal_osc(osc), .supply_above_0v9(above),
      .supply_below_trip(below)
   );
   // Clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Count pulses towards the core
   always @(posedge ref_clk)
   begin
      if (chip_reset === 1'b1)
         rst_seen <= rst_seen + 1;
      if (pc_sp_clear === 1'b1)
         psc_seen <= psc_seen + 1;
   end
   task automatic summarize();
      if (failures == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One transfer; the trailing idle edge keeps drives one per step
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      while (n == 0 || pready !== 1'b1)
      begin
         @(posedge ref_clk);
         n++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready wait", 32'h0000_0001, 32'(n));
      @(posedge ref_clk);
   endtask
   task automatic rchk(input string what, input logic [7:0] a,
      input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, exp, rd);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge ref_clk iff osc === 1'b1);
   endtask
   // Reset must follow within a bound, counted from the saved tally
   task automatic wait_rst(input int lim_c, input string what);
      int n;
      n = 0;
      while (rst_seen == s && n < lim_c)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk(what, 32'(s + 1), 32'(rst_seen));
      apb(1'b1, A_TRIP, GOOD);
   endtask
   function automatic int lim(input logic [1:0] c);
      return c == 2'h0 ? 8 : 16 << c;
   endfunction
   function automatic logic [1:0] vidx(input logic [7:0] c);
      return c == lvrst_pkg::CODE_2V55 ? 2'h1 :
         c == lvrst_pkg::CODE_3V15 ? 2'h2 :
         c == lvrst_pkg::CODE_3V80 ? 2'h3 : 2'h0;
   endfunction
   function automatic logic def_code(input logic [7:0] c);
      return c == lvrst_pkg::CODE_2V10 || vidx(c) != 2'h0;
   endfunction
   // Sag one tick short of the width, then one tick past it
   task automatic uv(input logic [1:0] c);
      apb(1'b1, A_WID, ($urandom & 32'hffff_fffc) | {30'h0, c});
      rchk("width", A_WID, {30'h0, c});
      apb(1'b1, A_FLG, 32'h0000_0000);
      s = rst_seen;
      ticks(1);
      sag <= 1'b1;
      ticks(lim(c) - 1);
      sag <= 1'b0;
      ticks(2);
      chk("short sag", 32'(s), 32'(rst_seen));
      sag <= 1'b1;
      ticks(lim(c) + 1);
      sag <= 1'b0;
      ticks(1);
      chk("long sag", 32'(s + 1), 32'(rst_seen));
      rchk("lv flag", A_FLG, 32'h0000_0004);
      rchk("trip kept", A_TRIP, GOOD);
   endtask
   task automatic fault(input logic w);
      apb(1'b1, A_FLG, 32'h0000_0000);
      s = rst_seen;
      pin_flt <= !w;
      wd_flt <= w;
      @(posedge ref_clk);
      pin_flt <= 1'b0;
      wd_flt <= 1'b0;
      wait_rst(8, "fault rst");
      apb(1'b0, A_FLG, 32'h0000_0000);
      chk("fault flag", w ? 32'h0000_0001 : 32'h0000_0008, rd & 32'h9);
   endtask
   // Guard against a hang
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      summarize();
   end
   // Main sequence
   initial
   begin
      {psel, penable, pwrite, sag, dead, sleep_idle} = '0;
      {wdt_timeout, pin_flt, wd_flt} = '0;
      paddr = '0;
      pwdata = '0;
      reset = 1'b1;
      codes = '{lvrst_pkg::CODE_2V55, lvrst_pkg::CODE_3V15,
         lvrst_pkg::CODE_3V80, lvrst_pkg::CODE_2V10};
      seed_v = $urandom(32'h0000_08ed);
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      rchk("trip por", A_TRIP, 32'h0000_0055);
      apb(1'b1, A_TRIP, GOOD);
      rchk("width por", A_WID, 32'h0000_0001);
      rchk("status por", lvrst_pkg::OFS_STATUS, 32'h0000_0000);
      apb(1'b1, A_FLG, 32'hffff_ffff);
      rchk("flags set", A_FLG, 32'h0000_0002);
      apb(1'b1, A_FLG, 32'h0000_0000);
      rchk("flags clr", A_FLG, 32'h0000_0000);
      rchk("unmapped", 8'h14, 32'h0000_0000);
      chk("slverr", 32'h0000_0001, {31'h0, err});
      foreach (codes[i])
      begin
         apb(1'b1, A_TRIP, {24'h0, codes[i]});
         repeat (2) @(posedge ref_clk);
         chk("level", {30'h0, vidx(codes[i])}, {30'h0, trip_voltage});
      end
      for (int c = 0; c < 4; c++)
         uv(2'(c));
      dead <= 1'b1;
      ticks(40);
      dead <= 1'b0;
      chk("dead", 32'(s + 1), 32'(rst_seen));
      s = rst_seen;
      wdt_timeout <= 1'b1;
      @(posedge ref_clk);
      wdt_timeout <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("wdt rst", 32'(s + 1), 32'(rst_seen));
      chk("tmo only", 32'h0000_0001, {30'h0, pwd_f, tmo_f});
      apb(1'b1, A_TRIP, GOOD);
      s = rst_seen;
      sleep_idle <= 1'b1;
      @(posedge ref_clk);
      ticks(1);
      chk("mon off", 32'h0000_0000, {31'h0, mon});
      sag <= 1'b1;
      ticks(40);
      sag <= 1'b0;
      wdt_timeout <= 1'b1;
      @(posedge ref_clk);
      wdt_timeout <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("asleep", 32'(s), 32'(rst_seen));
      chk("pc sp", 32'h0000_0001, 32'(psc_seen));
      chk("tmo pwd", 32'h0000_0003, {30'h0, pwd_f, tmo_f});
      bad = 8'($urandom);
      while (def_code(bad))
         bad = 8'($urandom);
      apb(1'b1, A_FLG, 32'h0000_0000);
      s = rst_seen;
      apb(1'b1, A_TRIP, {24'h0, bad});
      wait_rst(40, "bad rst");
      rchk("bad flag", A_FLG, 32'h0000_0002);
      sleep_idle <= 1'b0;
      s = rst_seen;
      apb(1'b1, lvrst_pkg::OFS_PROG, 32'h0000_0054);
      rchk("prog rd", lvrst_pkg::OFS_PROG, 32'h0000_0000);
      chk("prog other", 32'(s), 32'(rst_seen));
      apb(1'b1, lvrst_pkg::OFS_PROG, 32'h0000_0055);
      wait_rst(8, "prog rst");
      fault(1'b0);
      fault(1'b1);
      summarize();
   end
endmodule
`default_nettype wire

//--- test/lvrst_supply_model.sv
`timescale 1ns/100ps
`default_nettype none
module lvrst_supply_model
#(
   parameter int TICK_DIV = 4
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Commanded supply state
   input wire logic sag,
   input wire logic dead,
   // Comparator and slow oscillator
   output logic slow_internal_osc,
   output logic supply_above_0v9,
   output logic supply_below_trip
);
   int div_cnt;
   // Slow oscillator divider; a short period keeps the longest width brief
   always_ff @(posedge ref_clk)
   begin
      if (reset || div_cnt == TICK_DIV - 1)
         div_cnt <= 0;
      else
         div_cnt <= div_cnt + 1;
   end
   assign slow_internal_osc = (div_cnt == TICK_DIV - 1);
   // A dead supply also sits below trip, so only the window reads low
   assign supply_above_0v9 = !dead;
   assign supply_below_trip = sag || dead;
endmodule
`default_nettype wire
